// file: common/pcra_pkg.sv
// Purpose: Shared constants and types for the configuration register block
// Assumes: 22-bit word address, 16-bit multiplexed address/data bus
// Notes:   Field positions refer to the bus configuration register

package pcra_pkg;

    localparam int          ADDR_W       = 22;
    localparam int          DATA_W       = 16;

    // ------------------------------------------------------------------
    // Reset values and special addresses
    // ------------------------------------------------------------------
    localparam logic [15:0] BCR_RESET    = 16'h9D1F;
    localparam logic [15:0] RCR_RESET    = 16'h0010;
    localparam logic [21:0] TOP_ADDR     = 22'h3FFFFF;

    // ------------------------------------------------------------------
    // Register selection codes (address bits 19:18)
    // ------------------------------------------------------------------
    localparam int          RSEL_LSB     = 18;
    localparam logic [1:0]  RSEL_RCR     = 2'h0;
    localparam logic [1:0]  RSEL_DID     = 2'h1;
    localparam logic [1:0]  RSEL_BCR     = 2'h2;

    // Third-step data of the software sequence
    localparam logic [15:0] SW_SEL_RCR   = 16'h0000;
    localparam logic [15:0] SW_SEL_BCR   = 16'h0001;
    localparam logic [15:0] SW_SEL_DID   = 16'h0002;

    // ------------------------------------------------------------------
    // Bus configuration field positions
    // ------------------------------------------------------------------
    localparam int          LEN_LSB      = 0;
    localparam int          WRAP_BIT     = 3;
    localparam int          DRV_LSB      = 4;
    localparam int          WPOL_BIT     = 10;
    localparam int          LAT_LSB      = 11;
    localparam int          MODE_BIT     = 15;

    // Burst length codes
    localparam logic [2:0]  LEN_4        = 3'h1;
    localparam logic [2:0]  LEN_8        = 3'h2;
    localparam logic [2:0]  LEN_16       = 3'h3;
    localparam logic [2:0]  LEN_32       = 3'h4;
    localparam logic [2:0]  LEN_CONT     = 3'h7;

    // Latency code zero stands for eight clocks
    localparam logic [3:0]  LAT_ZERO_CLK = 4'h8;

    typedef enum logic [3:0] {
        SW_IDLE = 4'h1,
        SW_RD1  = 4'h2,
        SW_RD2  = 4'h4,
        SW_SEL  = 4'h8
    } pcra_sw_t;

endpackage

// file: rtl/pcra_burst_addr.sv
// Purpose: Burst address generator honouring length and wrap settings
// Assumes: Length code and wrap bit are stable during a burst
// Notes:   Used for both read and write bursts

`timescale 1ns/10ps

module pcra_burst_addr #(
    parameter int AW = 22
) (
    input  wire logic          i_clk,
    input  wire logic          i_rst,
    input  wire logic          i_load,
    input  wire logic [AW-1:0] i_start,
    input  wire logic          i_step,
    input  wire logic [2:0]    i_len,
    input  wire logic          i_wrap,
    output logic      [AW-1:0] o_addr,
    output logic               o_done
);

    function automatic logic [4:0] len_mask(input logic [2:0] code);
        case (code)
            pcra_pkg::LEN_4:  len_mask = 5'h03;
            pcra_pkg::LEN_8:  len_mask = 5'h07;
            pcra_pkg::LEN_16: len_mask = 5'h0F;
            pcra_pkg::LEN_32: len_mask = 5'h1F;
            default:          len_mask = 5'h00;
        endcase
    endfunction

    logic [4:0]    mask;
    logic          fixed;
    logic [4:0]    low_inc;
    logic [AW-1:0] next_addr;
    logic [5:0]    cnt;

    assign mask    = len_mask(i_len);
    assign fixed   = (mask != 5'h00);
    assign low_inc = o_addr[4:0] + 5'h01;

    // Continuous and unwrapped bursts roll over past the top address
    always_comb begin
        if (i_wrap && fixed) begin
            next_addr = {o_addr[AW-1:5],
                         (o_addr[4:0] & ~mask) | (low_inc & mask)};
        end else begin
            next_addr = o_addr + {{(AW-1){1'b0}}, 1'b1};
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_addr <= '0;
        end else if (i_load) begin
            o_addr <= i_start;
        end else if (i_step) begin
            o_addr <= next_addr;
        end
    end

    // Fixed bursts stop after the programmed number of words
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            cnt    <= 6'h00;
            o_done <= 1'b0;
        end else if (i_load) begin
            cnt    <= 6'h00;
            o_done <= 1'b0;
        end else if (i_step) begin
            cnt    <= cnt + 6'h01;
            o_done <= fixed && (cnt == {1'b0, mask});
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    property p_wrap_step;
        @(posedge i_clk) disable iff (i_rst)
        (i_step && !i_load && i_wrap && fixed) |=>
            (o_addr[4:0] == (($past(o_addr[4:0]) & ~$past(mask))
                | (($past(o_addr[4:0]) + 5'h01) & $past(mask))));
    endproperty
    a_wrap_step: assert property (p_wrap_step)
        else $error("wrapped burst address wrong");

    property p_linear_step;
        @(posedge i_clk) disable iff (i_rst)
        (i_step && !i_load && !(i_wrap && fixed)) |=>
            (o_addr == $past(o_addr) + {{(AW-1){1'b0}}, 1'b1});
    endproperty
    a_linear_step: assert property (p_linear_step)
        else $error("linear burst address did not advance by one");

    sequence s_four_steps;
        (i_step && !i_load) [*4];
    endsequence
    // Latency keeps the first step away from the load, so start on cnt
    property p_len4_done;
        @(posedge i_clk) disable iff (i_rst)
        (i_len == pcra_pkg::LEN_4 && cnt == 6'h00)
            ##0 s_four_steps |=> o_done;
    endproperty
    a_len4_done: assert property (p_len4_done)
        else $error("four word burst did not end after four words");

endmodule // pcra_burst_addr

// file: rtl/pcra_top.sv
// Purpose: Configuration register access and burst sequencing
// Assumes: Bus pins are sampled by i_clk through two-stage synchronisers;
//          the array is on-chip logic answering o_arr_addr combinationally
// Notes:   Rules carried out by this block follow

`timescale 1ns/10ps

module pcra_top #(
    // Arbitrary neutral identity value
    parameter logic [15:0] DEVICE_ID = 16'h0A5A
) (
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    input  wire logic        i_ce_n,
    input  wire logic        i_we_n,
    input  wire logic        i_oe_n,
    input  wire logic        i_adv_n,
    input  wire logic        i_register_select_input,
    input  wire logic [5:0]  i_addr_hi,
    input  wire logic [15:0] i_adq,
    input  wire logic [15:0] i_arr_rdata,
    output logic      [15:0] o_adq,
    output logic             o_adq_oe_n,
    output logic             o_wait,
    output logic      [1:0]  o_drive_strength,
    output logic      [21:0] o_arr_addr,
    output logic             o_arr_we,
    output logic      [15:0] o_arr_wdata,
    output logic      [15:0] o_bus_configuration,
    output logic      [15:0] o_refresh_configuration
);

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    localparam int PW = 27;
    logic [PW-1:0] pin_meta;
    logic [PW-1:0] pin_sync;
    logic          s_ce_n, s_we_n, s_oe_n, s_adv_n, s_rsel;
    logic [5:0]    s_ahi;
    logic [15:0]   s_adq;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            pin_meta <= {5'h1F, 22'h000000};
            pin_sync <= {5'h1F, 22'h000000};
        end else begin
            pin_meta <= {i_ce_n, i_we_n, i_oe_n, i_adv_n,
                         i_register_select_input, i_addr_hi, i_adq};
            pin_sync <= pin_meta;
        end
    end

    assign {s_ce_n, s_we_n, s_oe_n, s_adv_n, s_rsel, s_ahi, s_adq} = pin_sync;

    // ------------------------------------------------------------------
    // Registers and decoded fields
    // ------------------------------------------------------------------
    logic [15:0]         bus_configuration;
    logic [15:0]         refresh_configuration;
    pcra_pkg::pcra_sw_t  sw_state;
    logic [1:0]          sw_tgt;
    logic                sync_mode;

    assign sync_mode = !bus_configuration[pcra_pkg::MODE_BIT];

    function automatic logic [15:0] reg_read(input logic [1:0] sel,
                                             input logic [15:0] b,
                                             input logic [15:0] r);
        if (sel == pcra_pkg::RSEL_BCR) begin
            reg_read = b;
        end else if (sel == pcra_pkg::RSEL_RCR) begin
            reg_read = r;
        end else if (sel == pcra_pkg::RSEL_DID) begin
            reg_read = DEVICE_ID;
        end else begin
            reg_read = 16'h0000;
        end
    endfunction

    // ------------------------------------------------------------------
    // Access tracking
    // ------------------------------------------------------------------
    logic        active;
    logic        acc_reg;
    logic        acc_wr;
    logic [21:0] acc_addr;
    logic [15:0] acc_wdata;
    logic [3:0]  lat_cnt;
    logic        adv_take;
    logic        acc_end;
    logic        data_phase;
    logic        at_top;
    logic        sw_hit;
    logic        xfer;
    logic        burst_done;
    logic [21:0] burst_addr;
    logic [3:0]  lat_load;

    assign adv_take   = !s_ce_n && !s_adv_n;
    assign acc_end    = active && s_ce_n;
    assign data_phase = active && !s_ce_n && s_adv_n;
    assign at_top     = (acc_addr == pcra_pkg::TOP_ADDR);
    assign sw_hit     = at_top && !acc_reg && (sw_state == pcra_pkg::SW_SEL);
    assign lat_load   = (bus_configuration[pcra_pkg::LAT_LSB +: 3] == 3'h0)
                      ? pcra_pkg::LAT_ZERO_CLK
                      : {1'b0, bus_configuration[pcra_pkg::LAT_LSB +: 3]};
    // Register accesses are single words; only array bursts step
    assign xfer       = sync_mode && data_phase && !acc_reg && !burst_done
                      && (lat_cnt == 4'h0) && (!s_oe_n || !s_we_n);

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            active   <= 1'b0;
            acc_reg  <= 1'b0;
            acc_addr <= 22'h000000;
        end else if (adv_take) begin
            active   <= 1'b1;
            acc_reg  <= s_rsel;
            acc_addr <= {s_ahi, s_adq};
        end else if (acc_end) begin
            active   <= 1'b0;
        end
    end

    // Last data seen while the write strobe is low is the latched value
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            acc_wr    <= 1'b0;
            acc_wdata <= 16'h0000;
        end else if (adv_take) begin
            acc_wr    <= 1'b0;
        end else if (data_phase && !s_we_n) begin
            acc_wr    <= 1'b1;
            acc_wdata <= s_adq;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            lat_cnt <= 4'h0;
        end else if (adv_take) begin
            lat_cnt <= lat_load;
        end else if (data_phase && lat_cnt != 4'h0) begin
            lat_cnt <= lat_cnt - 4'h1;
        end
    end

    pcra_burst_addr #(
        .AW      (pcra_pkg::ADDR_W)
    ) u_burst (
        .i_clk   (i_clk),
        .i_rst   (i_rst),
        .i_load  (adv_take),
        .i_start ({s_ahi, s_adq}),
        .i_step  (xfer),
        .i_len   (bus_configuration[pcra_pkg::LEN_LSB +: 3]),
        .i_wrap  (!bus_configuration[pcra_pkg::WRAP_BIT]),
        .o_addr  (burst_addr),
        .o_done  (burst_done)
    );

    // ------------------------------------------------------------------
    // Software sequence detector
    // ------------------------------------------------------------------
    logic        sw_sel_ok;
    logic [1:0]  sw_sel_code;

    always_comb begin
        sw_sel_ok   = 1'b1;
        sw_sel_code = pcra_pkg::RSEL_RCR;
        if (acc_wdata == pcra_pkg::SW_SEL_BCR) begin
            sw_sel_code = pcra_pkg::RSEL_BCR;
        end else if (acc_wdata == pcra_pkg::SW_SEL_DID) begin
            sw_sel_code = pcra_pkg::RSEL_DID;
        end else if (acc_wdata != pcra_pkg::SW_SEL_RCR) begin
            sw_sel_ok   = 1'b0;
        end
    end

    // Only asynchronous array accesses count as sequence steps
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            sw_state <= pcra_pkg::SW_IDLE;
            sw_tgt   <= pcra_pkg::RSEL_RCR;
        end else if (acc_end && !acc_reg) begin
            if (!at_top || sync_mode) begin
                sw_state <= pcra_pkg::SW_IDLE;
            end else begin
                case (sw_state)
                    pcra_pkg::SW_IDLE: begin
                        sw_state <= acc_wr ? pcra_pkg::SW_IDLE
                                           : pcra_pkg::SW_RD1;
                    end
                    pcra_pkg::SW_RD1: begin
                        sw_state <= acc_wr ? pcra_pkg::SW_IDLE
                                           : pcra_pkg::SW_RD2;
                    end
                    pcra_pkg::SW_RD2: begin
                        if (!acc_wr) begin
                            sw_state <= pcra_pkg::SW_RD2;
                        end else if (sw_sel_ok) begin
                            sw_state <= pcra_pkg::SW_SEL;
                            sw_tgt   <= sw_sel_code;
                        end else begin
                            sw_state <= pcra_pkg::SW_IDLE;
                        end
                    end
                    pcra_pkg::SW_SEL: begin
                        sw_state <= pcra_pkg::SW_IDLE;
                    end
                    default: begin
                        sw_state <= pcra_pkg::SW_IDLE;
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------------
    logic        reg_wr;
    logic [1:0]  reg_wsel;
    logic [15:0] reg_wval;

    // Select-input writes carry the value in the address phase
    assign reg_wr   = acc_end && acc_wr && (acc_reg || sw_hit);
    assign reg_wsel = acc_reg ? acc_addr[pcra_pkg::RSEL_LSB +: 2]
                              : sw_tgt;
    assign reg_wval = acc_reg ? acc_addr[15:0] : acc_wdata;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            bus_configuration <= pcra_pkg::BCR_RESET;
            refresh_configuration <= pcra_pkg::RCR_RESET;
        end else if (reg_wr) begin
            // Identity writes fall through untouched
            if (reg_wsel == pcra_pkg::RSEL_BCR) begin
                bus_configuration <= reg_wval;
            end else if (reg_wsel == pcra_pkg::RSEL_RCR) begin
                refresh_configuration <= reg_wval;
            end
        end
    end

    // ------------------------------------------------------------------
    // Array port
    // ------------------------------------------------------------------
    logic arr_wr_async;
    logic sw_write;

    // Sequence writes at the top address never reach the array
    assign sw_write     = at_top && (sw_state == pcra_pkg::SW_SEL
                        || (sw_state == pcra_pkg::SW_RD2 && sw_sel_ok));
    assign arr_wr_async = acc_end && acc_wr && !acc_reg && !sync_mode
                        && !sw_write;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_arr_addr  <= 22'h000000;
            o_arr_we    <= 1'b0;
            o_arr_wdata <= 16'h0000;
        end else begin
            o_arr_addr  <= burst_addr;
            o_arr_we    <= arr_wr_async || (xfer && !s_we_n);
            o_arr_wdata <= (xfer && !s_we_n) ? s_adq : acc_wdata;
        end
    end

    // ------------------------------------------------------------------
    // Read data and status outputs
    // ------------------------------------------------------------------
    logic rd_phase;

    assign rd_phase = data_phase && !s_oe_n;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_adq      <= 16'h0000;
            o_adq_oe_n <= 1'b1;
        end else begin
            o_adq_oe_n <= !rd_phase;
            if (acc_reg) begin
                o_adq <= reg_read(acc_addr[pcra_pkg::RSEL_LSB +: 2],
                                  bus_configuration, refresh_configuration);
            end else if (sw_hit) begin
                o_adq <= reg_read(sw_tgt, bus_configuration, refresh_configuration);
            end else begin
                o_adq <= i_arr_rdata;
            end
        end
    end

    // Wait is active during the latency count of synchronous accesses; the WPOL bit sets its level
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_wait <= 1'b0;
        end else begin
            o_wait <= (sync_mode && data_phase && lat_cnt != 4'h0)
                   ~^ bus_configuration[pcra_pkg::WPOL_BIT];
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_drive_strength        <=
                pcra_pkg::BCR_RESET[pcra_pkg::DRV_LSB +: 2];
            o_bus_configuration     <= pcra_pkg::BCR_RESET;
            o_refresh_configuration <= pcra_pkg::RCR_RESET;
        end else begin
            o_drive_strength        <= bus_configuration[pcra_pkg::DRV_LSB +: 2];
            o_bus_configuration     <= bus_configuration;
            o_refresh_configuration <= refresh_configuration;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    property p_bcr_reset;
        @(posedge i_clk) $past(i_rst) |-> bus_configuration == pcra_pkg::BCR_RESET;
    endproperty
    a_bcr_reset: assert property (p_bcr_reset)
        else $error("bus configuration not at reset value");

    property p_sw_no_array;
        @(posedge i_clk) disable iff (i_rst)
        (acc_end && acc_wr && sw_write) |=> !o_arr_we;
    endproperty
    a_sw_no_array: assert property (p_sw_no_array)
        else $error("software sequence wrote the array");

    property p_reg_no_array;
        @(posedge i_clk) disable iff (i_rst)
        (acc_end && acc_reg) |=> !o_arr_we;
    endproperty
    a_reg_no_array: assert property (p_reg_no_array)
        else $error("register access wrote the array");

    property p_sel_bcr;
        @(posedge i_clk) disable iff (i_rst)
        (acc_end && !acc_reg && !sync_mode && at_top && acc_wr
         && sw_state == pcra_pkg::SW_RD2
         && acc_wdata == pcra_pkg::SW_SEL_BCR)
            |=> sw_state == pcra_pkg::SW_SEL && sw_tgt == pcra_pkg::RSEL_BCR;
    endproperty
    a_sel_bcr: assert property (p_sel_bcr)
        else $error("third step did not select bus configuration");

    property p_break;
        @(posedge i_clk) disable iff (i_rst)
        (acc_end && !acc_reg && !at_top) |=> sw_state == pcra_pkg::SW_IDLE;
    endproperty
    a_break: assert property (p_break)
        else $error("sequence kept after a foreign address");

    property p_readback;
        @(posedge i_clk) disable iff (i_rst)
        (reg_wr && reg_wsel == pcra_pkg::RSEL_BCR)
            |=> ##1 o_bus_configuration == $past(reg_wval, 2);
    endproperty
    a_readback: assert property (p_readback)
        else $error("bus configuration not as written");

    property p_id_ro;
        @(posedge i_clk) disable iff (i_rst)
        (reg_wr && reg_wsel == pcra_pkg::RSEL_DID) |=> $stable(bus_configuration)
            && $stable(refresh_configuration);
    endproperty
    a_id_ro: assert property (p_id_ro)
        else $error("identity write changed a register");

    property p_drive;
        @(posedge i_clk) disable iff (i_rst)
        $changed(bus_configuration[pcra_pkg::DRV_LSB +: 2])
            |=> o_drive_strength == $past(bus_configuration[pcra_pkg::DRV_LSB +: 2]);
    endproperty
    a_drive: assert property (p_drive)
        else $error("drive strength output does not follow field");

    property p_cre_any_state;
        @(posedge i_clk) disable iff (i_rst)
        (acc_end && acc_reg && acc_wr
         && acc_addr[pcra_pkg::RSEL_LSB +: 2] == pcra_pkg::RSEL_RCR)
            |=> refresh_configuration == $past(acc_addr[15:0]);
    endproperty
    a_cre_any_state: assert property (p_cre_any_state)
        else $error("select-input write to refresh register lost");

endmodule // pcra_top

// file: sim/pcra_ctrl_model.sv
// Purpose: Memory controller model on the multiplexed pin bus
// Assumes: Fixed-length accesses, also used for synchronous bursts, with wait ignored; pins change on falling edges
// Notes:   Released data lines show the inverse of the last value

`timescale 1ns/10ps

module pcra_ctrl_model (
    input  wire logic        i_clk,
    input  wire logic [15:0] i_adq,
    output logic             o_ce_n,
    output logic             o_we_n,
    output logic             o_oe_n,
    output logic             o_adv_n,
    output logic             o_register_select,
    output logic      [5:0]  o_addr_hi,
    output logic      [15:0] o_adq
);
    initial begin
        {o_ce_n, o_we_n, o_oe_n, o_adv_n} = 4'hF;
        o_register_select = 1'b0;
        {o_addr_hi, o_adq} = 22'h000000;
    end

    // Phases last several clocks so the two sync stages see each one
    task automatic acc(input logic s, input logic [21:0] a, input logic w,
                       input logic [15:0] d, output logic [15:0] q);
        @(negedge i_clk);
        {o_ce_n, o_adv_n, o_register_select} = {2'b00, s};
        {o_addr_hi, o_adq} = a;
        repeat (3) @(negedge i_clk);
        {o_adv_n, o_we_n, o_oe_n} = {1'b1, !w, w};
        o_adq = w ? d : ~a[15:0];
        repeat (6) @(negedge i_clk);
        q = i_adq;
        {o_ce_n, o_we_n, o_oe_n} = 3'h7;
        o_adq = ~o_adq;
        repeat (6) @(negedge i_clk);
    endtask

    task automatic sw(input logic w, input logic [15:0] sel,
                      input logic [15:0] d, output logic [15:0] q);
        logic [15:0] t;
        acc(1'b0, pcra_pkg::TOP_ADDR, 1'b0, 16'h0000, t);
        acc(1'b0, pcra_pkg::TOP_ADDR, 1'b0, 16'h0000, t);
        acc(1'b0, pcra_pkg::TOP_ADDR, 1'b1, sel, t);
        acc(1'b0, pcra_pkg::TOP_ADDR, w, d, q);
    endtask
endmodule // pcra_ctrl_model

// file: sim/psram_config_register_access_tb_top.sv
// Purpose: Self-checking bench for the configuration register block
// Assumes: Array answers with its address xor 5A5A
// Notes:   Async accesses plus two synchronous four-word read bursts, one wrapped and one linear

`timescale 1ns/10ps

module psram_config_register_access_tb_top;
    typedef struct packed {
        logic        s;
        logic [21:0] a;
        logic        w;
        logic [15:0] e;
    } pcra_row_t;
    // Arbitrary identity value
    localparam logic [15:0] DID = 16'h0A5A;
    localparam pcra_row_t ROWS [7] = '{
        '{1'b1, 22'h089D21, 1'b1, 16'h9D21}, '{1'b1, 22'h080000, 1'b0, 16'h9D21},
        '{1'b1, 22'h000013, 1'b1, 16'h9D21}, '{1'b1, 22'h000000, 1'b0, 16'h0013},
        '{1'b1, 22'h04FFFF, 1'b1, 16'h9D21},
        '{1'b1, 22'h040000, 1'b0, DID}, '{1'b0, 22'h000123, 1'b0, 16'h5B79}};
    localparam logic [15:0] EXP [3] = '{16'h0013, 16'h9D13, DID};
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        ce_n, we_n, oe_n, adv_n, rsel, adq_oe_n, wt, arr_we;
    logic [5:0]  hi;
    logic [1:0]  drv;
    logic [21:0] aa;
    logic [15:0] adq_i, adq_o, rdat, wdat, bus_configuration, refresh_configuration, q, lwa, lwd;
    logic [15:0] nwr = 16'h0000;
    logic [15:0] hist = 16'h0000;
    logic [21:0] pa = 22'h000000;
    int          errors = 0;
    int          tests_run = 0;

    always #5 clk = ~clk;
    assign rdat = aa[15:0] ^ 16'h5A5A;

    pcra_ctrl_model i_ctl (.i_clk(clk), .i_adq(adq_o), .o_ce_n(ce_n),
        .o_we_n(we_n), .o_oe_n(oe_n), .o_adv_n(adv_n),
        .o_register_select(rsel), .o_addr_hi(hi), .o_adq(adq_i));
    pcra_top #(.DEVICE_ID(DID)) i_dut (.i_clk(clk), .i_rst(rst),
        .i_ce_n(ce_n), .i_we_n(we_n), .i_oe_n(oe_n), .i_adv_n(adv_n),
        .i_register_select_input(rsel), .i_addr_hi(hi), .i_adq(adq_i),
        .i_arr_rdata(rdat), .o_adq(adq_o), .o_adq_oe_n(adq_oe_n),
        .o_wait(wt), .o_drive_strength(drv), .o_arr_addr(aa),
        .o_arr_we(arr_we), .o_arr_wdata(wdat), .o_bus_configuration(bus_configuration),
        .o_refresh_configuration(refresh_configuration));

    always @(posedge clk)
        if (arr_we === 1'b1) begin
            nwr <= nwr + 16'h0001;
            lwa <= aa[15:0];
            lwd <= wdat;
        end

    // Low nibbles of the last four array addresses shown
    always @(posedge clk)
        if (aa !== pa) begin
            pa   <= aa;
            hist <= {hist[11:0], aa[3:0]};
        end

    task automatic chk(input string n, input logic [15:0] s, e);
        tests_run++;
        if (s !== e) begin
            errors++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d errors %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial begin
        repeat (6000) @(posedge clk);
        errors++;
        complete_run();
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (3) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        chk("bcr", bus_configuration, 16'h9D1F);
        chk("rcr", refresh_configuration, 16'h0010);
        chk("drv", {14'h0, drv}, 16'h0001);
        chk("idle", {adq_oe_n, wt}, 16'h0002);
        $display("test reset done");
        foreach (ROWS[i]) begin
            i_ctl.acc(ROWS[i].s, ROWS[i].a, ROWS[i].w, ROWS[i].a[15:0], q);
            chk("row", ROWS[i].w ? bus_configuration : q, ROWS[i].e);
        end
        chk("drv", {14'h0, drv}, 16'h0002);
        $display("test select input done");
        i_ctl.sw(1'b1, 16'h0001, 16'h9D13, q);
        chk("bcr", bus_configuration, 16'h9D13);
        chk("drv", {14'h0, drv}, 16'h0001);
        chk("writes", nwr, 16'h0000);
        i_ctl.sw(1'b1, 16'h0002, 16'h1111, q);
        for (int k = 0; k < 3; k++) begin
            i_ctl.sw(1'b0, 16'(k), 16'h0000, q);
            chk("swrd", q, EXP[k]);
        end
        $display("test software sequence done");
        for (int k = 0; k < 5; k++)
            i_ctl.acc(1'b0, k == 2 ? 22'h0 : pcra_pkg::TOP_ADDR, k > 2,
                      k == 3 ? 16'h0001 : 16'h1234, q);
        chk("bcr", bus_configuration, 16'h9D13);
        chk("writes", nwr, 16'h0002);
        chk("waddr", lwa, 16'hFFFF);
        chk("wdata", lwd, 16'h1234);
        $display("test broken sequence done");
        // Synchronous four-word bursts from word 6, wrapped then linear
        for (int k = 0; k < 2; k++) begin
            i_ctl.acc(1'b1, k ? 22'h080C19 : 22'h080C11, 1'b1, 16'h0000, q);
            i_ctl.acc(1'b0, 22'h000006, 1'b0, 16'h0000, q);
            chk("bq", q, 16'h5A5D);
            chk("bseq", hist, k ? 16'h789A : 16'h7456);
        end
        $display("test burst done");
        rst = 1'b1;
        repeat (3) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        chk("bcr", bus_configuration, 16'h9D1F);
        chk("rcr", refresh_configuration, 16'h0010);
        $display("test mid reset done");
        complete_run();
    end
endmodule // psram_config_register_access_tb_top
